// *** design/eim_ctrl.sv ***
// Interrupt enable mask and cause flags of the Ethernet controller
`timescale 1ns/1ps
`default_nettype none
module eim_ctrl (
    // Clock and reset
    input  wire logic               sys_clk_i,
    input  wire logic               rst_i,
    // Register port
    input  wire eim_pkg::eim_req_t  req_i,
    output logic [15:0]             rdata_o,
    // Event pulses from the engines
    input  wire eim_pkg::eim_events_t events_i,
    // Enable outputs and interrupt
    output logic [15:0]             irq_enable_o,
    output logic                    irq_o
);

    eim_pkg::eim_state_t state_reg;
    eim_pkg::eim_state_t state_next;

    // Bit 15 never holds state; stops a careless write from enabling a phantom source
    function automatic logic [15:0] keep_valid(input logic [15:0] v);
        return v & eim_pkg::VALID_BITS;
    endfunction

    // One source through its own enable, shared by all fifteen sources
    function automatic logic gate_bit(
        input logic [15:0] flags,
        input logic [15:0] enables,
        input int          pos
    );
        return flags[pos] & enables[pos];
    endfunction

    // Next state: mask writes, set-wins cause flags, read mux, interrupt level
    always_comb begin
        logic [15:0] clr;
        logic [15:0] mask_n;
        logic [15:0] cause_n;
        logic [15:0] gated;
        clr        = 16'h0000;
        mask_n     = state_reg.mask;
        cause_n    = state_reg.cause;
        gated      = 16'h0000;
        state_next = state_reg;
        if (req_i.wr && req_i.addr == eim_pkg::MASK_OFFSET) begin
            mask_n = keep_valid(req_i.wdata);
        end
        if (req_i.wr && req_i.addr == eim_pkg::CAUSE_OFFSET) begin
            clr = req_i.wdata;
        end
        // An event in the clearing cycle survives
        cause_n = keep_valid((state_reg.cause & ~clr) | events_i);
        state_next.mask  = mask_n;
        state_next.cause = cause_n;
        // Each source gated by its own enable; gating the next values rather
        // than the registered ones lets a mask change act within one cycle
        gated[eim_pkg::BIT_BUS_RETRY] =
            gate_bit(cause_n, mask_n, eim_pkg::BIT_BUS_RETRY);
        gated[eim_pkg::BIT_HEARTBEAT_MISSING] =
            gate_bit(cause_n, mask_n, eim_pkg::BIT_HEARTBEAT_MISSING);
        gated[eim_pkg::BIT_MATCH_TABLE] =
            gate_bit(cause_n, mask_n, eim_pkg::BIT_MATCH_TABLE);
        gated[eim_pkg::BIT_DESCRIPTOR_REQ] =
            gate_bit(cause_n, mask_n, eim_pkg::BIT_DESCRIPTOR_REQ);
        gated[eim_pkg::BIT_RX_PACKET] =
            gate_bit(cause_n, mask_n, eim_pkg::BIT_RX_PACKET);
        gated[eim_pkg::BIT_TX_COMPLETE] =
            gate_bit(cause_n, mask_n, eim_pkg::BIT_TX_COMPLETE);
        gated[eim_pkg::BIT_TX_FAULT] =
            gate_bit(cause_n, mask_n, eim_pkg::BIT_TX_FAULT);
        gated[eim_pkg::BIT_TIMER_WRAP] =
            gate_bit(cause_n, mask_n, eim_pkg::BIT_TIMER_WRAP);
        gated[eim_pkg::BIT_RX_DESC_EMPTY] =
            gate_bit(cause_n, mask_n, eim_pkg::BIT_RX_DESC_EMPTY);
        gated[eim_pkg::BIT_RX_RES_EMPTY] =
            gate_bit(cause_n, mask_n, eim_pkg::BIT_RX_RES_EMPTY);
        gated[eim_pkg::BIT_RX_AREA_OVERFLOW] =
            gate_bit(cause_n, mask_n, eim_pkg::BIT_RX_AREA_OVERFLOW);
        gated[eim_pkg::BIT_CHECKSUM_WRAP] =
            gate_bit(cause_n, mask_n, eim_pkg::BIT_CHECKSUM_WRAP);
        gated[eim_pkg::BIT_ALIGNMENT_WRAP] =
            gate_bit(cause_n, mask_n, eim_pkg::BIT_ALIGNMENT_WRAP);
        gated[eim_pkg::BIT_MISSED_WRAP] =
            gate_bit(cause_n, mask_n, eim_pkg::BIT_MISSED_WRAP);
        gated[eim_pkg::BIT_RX_FIFO_OVERRUN] =
            gate_bit(cause_n, mask_n, eim_pkg::BIT_RX_FIFO_OVERRUN);
        // Any gated source raises the line
        state_next.irq = |gated;
        if (req_i.rd) begin
            case (req_i.addr)
                eim_pkg::MASK_OFFSET:  state_next.rdata = state_reg.mask;
                eim_pkg::CAUSE_OFFSET: state_next.rdata = state_reg.cause;
                default:               state_next.rdata = eim_pkg::UNMAPPED_READ;
            endcase
        end else begin
            state_next.rdata = eim_pkg::UNMAPPED_READ;
        end
    end

    // State register, cleared by hardware reset
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg.mask  <= eim_pkg::MASK_RESET;
            state_reg.cause <= eim_pkg::CAUSE_RESET;
            state_reg.rdata <= eim_pkg::UNMAPPED_READ;
            state_reg.irq   <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign rdata_o      = state_reg.rdata;
    assign irq_enable_o = state_reg.mask;
    assign irq_o        = state_reg.irq;

    // Named steps of the register and event paths
    sequence seq_mask_write;
        req_i.wr && req_i.addr == eim_pkg::MASK_OFFSET;
    endsequence

    sequence seq_cause_write;
        req_i.wr && req_i.addr == eim_pkg::CAUSE_OFFSET;
    endsequence

    sequence seq_no_events;
        events_i == '0;
    endsequence

    // Interrupt follows flags and enables one cycle later
    chk_irq_follows_gate: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        1'b1 |=> irq_o == |($past(state_next.cause) & $past(state_next.mask)))
        else $error("interrupt does not match gated flags");

    // Mask write reaches the enable outputs next cycle
    chk_mask_write_lands: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        req_i.wr && req_i.addr == eim_pkg::MASK_OFFSET
        |=> irq_enable_o == ($past(req_i.wdata) & eim_pkg::VALID_BITS))
        else $error("mask write not taken");

    // Writing zero mask silences the line next cycle
    chk_mask_zero_quiet: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        req_i.wr && req_i.addr == eim_pkg::MASK_OFFSET && req_i.wdata == 16'h0000
        |=> !irq_o)
        else $error("interrupt active with mask cleared");

    // Packet received event pulse sets its flag even under a clear
    chk_event_sets_flag: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        events_i[eim_pkg::BIT_RX_PACKET] |=> state_reg.cause[eim_pkg::BIT_RX_PACKET])
        else $error("event flag lost");

    // Bit 15 of the mask stays clear
    chk_top_bit_zero: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        !irq_enable_o[15])
        else $error("mask bit 15 set");

    // Flag and enable both set: the line must be up in the same cycle
    property p_source_passes(int pos);
        @(posedge sys_clk_i) disable iff (rst_i)
        state_reg.cause[pos] && state_reg.mask[pos] |-> irq_o;
    endproperty

    // Only this flag pending and its enable clear: the line must stay down
    property p_source_blocked(int pos);
        @(posedge sys_clk_i) disable iff (rst_i)
        state_reg.cause == (16'h0001 << pos) && !state_reg.mask[pos] |-> !irq_o;
    endproperty

    // Bus retry flag passes when enabled
    chk_bus_retry_pass: assert property (p_source_passes(eim_pkg::BIT_BUS_RETRY))
        else $error("bus retry interrupt not passed");

    // Bus retry flag blocked when disabled
    chk_bus_retry_block: assert property (p_source_blocked(eim_pkg::BIT_BUS_RETRY))
        else $error("bus retry interrupt not blocked");

    // Heartbeat missing flag passes when enabled
    chk_hb_lost_pass: assert property (p_source_passes(eim_pkg::BIT_HEARTBEAT_MISSING))
        else $error("heartbeat interrupt not passed");

    // Heartbeat missing flag blocked when disabled
    chk_hb_lost_block: assert property (p_source_blocked(eim_pkg::BIT_HEARTBEAT_MISSING))
        else $error("heartbeat interrupt not blocked");

    // Match table loaded flag passes when enabled
    chk_table_pass: assert property (p_source_passes(eim_pkg::BIT_MATCH_TABLE))
        else $error("table loaded interrupt not passed");

    // Match table loaded flag blocked when disabled
    chk_table_block: assert property (p_source_blocked(eim_pkg::BIT_MATCH_TABLE))
        else $error("table loaded interrupt not blocked");

    // Descriptor request flag passes when enabled
    chk_desc_req_pass: assert property (p_source_passes(eim_pkg::BIT_DESCRIPTOR_REQ))
        else $error("descriptor interrupt not passed");

    // Descriptor request flag blocked when disabled
    chk_desc_req_block: assert property (p_source_blocked(eim_pkg::BIT_DESCRIPTOR_REQ))
        else $error("descriptor interrupt not blocked");

    // Packet received flag passes when enabled
    chk_rx_packet_pass: assert property (p_source_passes(eim_pkg::BIT_RX_PACKET))
        else $error("receive interrupt not passed");

    // Packet received flag blocked when disabled
    chk_rx_packet_block: assert property (p_source_blocked(eim_pkg::BIT_RX_PACKET))
        else $error("receive interrupt not blocked");

    // Transmit complete flag passes when enabled
    chk_tx_done_pass: assert property (p_source_passes(eim_pkg::BIT_TX_COMPLETE))
        else $error("transmit done interrupt not passed");

    // Transmit complete flag blocked when disabled
    chk_tx_done_block: assert property (p_source_blocked(eim_pkg::BIT_TX_COMPLETE))
        else $error("transmit done interrupt not blocked");

    // Transmit fault flag passes when enabled
    chk_tx_fault_pass: assert property (p_source_passes(eim_pkg::BIT_TX_FAULT))
        else $error("transmit fault interrupt not passed");

    // Transmit fault flag blocked when disabled
    chk_tx_fault_block: assert property (p_source_blocked(eim_pkg::BIT_TX_FAULT))
        else $error("transmit fault interrupt not blocked");

    // Timer wrap flag passes when enabled
    chk_timer_wrap_pass: assert property (p_source_passes(eim_pkg::BIT_TIMER_WRAP))
        else $error("timer interrupt not passed");

    // Timer wrap flag blocked when disabled
    chk_timer_wrap_block: assert property (p_source_blocked(eim_pkg::BIT_TIMER_WRAP))
        else $error("timer interrupt not blocked");

    // Receive descriptors empty flag passes when enabled
    chk_rx_desc_pass: assert property (p_source_passes(eim_pkg::BIT_RX_DESC_EMPTY))
        else $error("descriptors empty interrupt not passed");

    // Receive descriptors empty flag blocked when disabled
    chk_rx_desc_block: assert property (p_source_blocked(eim_pkg::BIT_RX_DESC_EMPTY))
        else $error("descriptors empty interrupt not blocked");

    // Receive resources empty flag passes when enabled
    chk_rx_res_pass: assert property (p_source_passes(eim_pkg::BIT_RX_RES_EMPTY))
        else $error("resources empty interrupt not passed");

    // Receive resources empty flag blocked when disabled
    chk_rx_res_block: assert property (p_source_blocked(eim_pkg::BIT_RX_RES_EMPTY))
        else $error("resources empty interrupt not blocked");

    // Receive area overflow flag passes when enabled
    chk_rx_area_pass: assert property (p_source_passes(eim_pkg::BIT_RX_AREA_OVERFLOW))
        else $error("area overflow interrupt not passed");

    // Receive area overflow flag blocked when disabled
    chk_rx_area_block: assert property (p_source_blocked(eim_pkg::BIT_RX_AREA_OVERFLOW))
        else $error("area overflow interrupt not blocked");

    // Checksum tally wrap flag passes when enabled
    chk_sum_tally_pass: assert property (p_source_passes(eim_pkg::BIT_CHECKSUM_WRAP))
        else $error("checksum tally interrupt not passed");

    // Checksum tally wrap flag blocked when disabled
    chk_sum_tally_block: assert property (p_source_blocked(eim_pkg::BIT_CHECKSUM_WRAP))
        else $error("checksum tally interrupt not blocked");

    // Alignment tally wrap flag passes when enabled
    chk_align_pass: assert property (p_source_passes(eim_pkg::BIT_ALIGNMENT_WRAP))
        else $error("alignment tally interrupt not passed");

    // Alignment tally wrap flag blocked when disabled
    chk_align_block: assert property (p_source_blocked(eim_pkg::BIT_ALIGNMENT_WRAP))
        else $error("alignment tally interrupt not blocked");

    // Missed packet tally wrap flag passes when enabled
    chk_missed_pass: assert property (p_source_passes(eim_pkg::BIT_MISSED_WRAP))
        else $error("missed tally interrupt not passed");

    // Missed packet tally wrap flag blocked when disabled
    chk_missed_block: assert property (p_source_blocked(eim_pkg::BIT_MISSED_WRAP))
        else $error("missed tally interrupt not blocked");

    // Receive FIFO overrun flag passes when enabled
    chk_fifo_ovr_pass: assert property (p_source_passes(eim_pkg::BIT_RX_FIFO_OVERRUN))
        else $error("overrun interrupt not passed");

    // Receive FIFO overrun flag blocked when disabled
    chk_fifo_ovr_block: assert property (p_source_blocked(eim_pkg::BIT_RX_FIFO_OVERRUN))
        else $error("overrun interrupt not blocked");

    // Leaving reset: no enable, no line and no read data
    chk_reset_clears_all: assert property (@(posedge sys_clk_i)
        $fell(rst_i) |-> irq_enable_o == eim_pkg::MASK_RESET && !irq_o
                         && rdata_o == eim_pkg::UNMAPPED_READ)
        else $error("state not cleared by reset");

    // Writing ones clears those flags when no event lands at the same time
    chk_cause_clear_one: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        seq_cause_write ##0 seq_no_events
        |=> state_reg.cause == ($past(state_reg.cause) & ~$past(req_i.wdata)))
        else $error("flags not cleared by a write of ones");

    // Writing zero to the flags leaves them as they were
    chk_cause_zero_keeps: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        seq_cause_write ##0 (req_i.wdata == 16'h0000) ##0 seq_no_events
        |=> state_reg.cause == $past(state_reg.cause))
        else $error("flags changed by a write of zero");

    // A mask write settles the line from the flags already pending
    chk_mask_change_acts: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        seq_mask_write ##0 seq_no_events
        |=> irq_o == |($past(req_i.wdata) & $past(state_reg.cause)))
        else $error("mask change not seen on the interrupt");

    // Enables move only on a write to the mask
    chk_mask_holds: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        !(req_i.wr && req_i.addr == eim_pkg::MASK_OFFSET) |=> $stable(irq_enable_o))
        else $error("enables changed without a mask write");

endmodule
`default_nettype wire

// *** common/eim_pkg.sv ***
// Constants and carrier types of the Ethernet interrupt enable mask block
// Summary of operation
// - A set enable bit passes its cause flag to the interrupt; a clear one blocks it.
// - Hardware reset clears every enable bit.
// - Bit 14 enables the bus retry interrupt.
// - Bit 13 enables the heartbeat missing interrupt.
// - Bit 12 enables the match table loaded interrupt.
// - Bit 11 enables the descriptor requested interrupt.
// - Bit 10 enables the packet received interrupt.
// - Bit 9 enables the transmit complete interrupt.
// - Bit 8 enables the transmit fault interrupt.
// - Bit 7 enables the timer wrap interrupt.
// - Bit 6 enables the receive descriptors empty interrupt.
// - Bit 5 enables the receive resources empty interrupt.
// - Bit 4 enables the receive area overflow interrupt.
// - Bit 3 enables the checksum tally wrap interrupt.
// - Bit 2 enables the alignment tally wrap interrupt.
// - Bit 1 enables the missed packet tally wrap interrupt.
// - Bit 0 enables the receive FIFO overrun interrupt.
// - Interrupt output is active when any cause flag and its enable are both set.
// - Writing one clears a cause flag; writing zero leaves it alone.
package eim_pkg;

    localparam int         REG_AW            = 6;
    localparam int         REG_DW            = 16;
    localparam logic [5:0] MASK_OFFSET       = 6'h04;
    localparam logic [5:0] CAUSE_OFFSET      = 6'h05;
    localparam logic [15:0] MASK_RESET       = 16'h0000;
    localparam logic [15:0] CAUSE_RESET      = 16'h0000;
    localparam logic [15:0] VALID_BITS       = 16'h7fff;
    localparam logic [15:0] UNMAPPED_READ    = 16'h0000;

    // Field positions, shared by mask and cause registers
    localparam int BIT_BUS_RETRY         = 14;
    localparam int BIT_HEARTBEAT_MISSING = 13;
    localparam int BIT_MATCH_TABLE       = 12;
    localparam int BIT_DESCRIPTOR_REQ    = 11;
    localparam int BIT_RX_PACKET         = 10;
    localparam int BIT_TX_COMPLETE       = 9;
    localparam int BIT_TX_FAULT          = 8;
    localparam int BIT_TIMER_WRAP        = 7;
    localparam int BIT_RX_DESC_EMPTY     = 6;
    localparam int BIT_RX_RES_EMPTY      = 5;
    localparam int BIT_RX_AREA_OVERFLOW  = 4;
    localparam int BIT_CHECKSUM_WRAP     = 3;
    localparam int BIT_ALIGNMENT_WRAP    = 2;
    localparam int BIT_MISSED_WRAP       = 1;
    localparam int BIT_RX_FIFO_OVERRUN   = 0;

    // One pulse per source, bit order matches the mask layout
    typedef struct packed {
        logic       reserved;
        logic       bus_retry;
        logic       heartbeat_missing;
        logic       match_table_loaded;
        logic       descriptor_request;
        logic       rx_packet;
        logic       tx_complete;
        logic       tx_fault;
        logic       timer_wrap;
        logic       rx_descriptors_empty;
        logic       rx_resources_empty;
        logic       rx_area_overflow;
        logic       checksum_tally_wrap;
        logic       alignment_tally_wrap;
        logic       missed_tally_wrap;
        logic       rx_fifo_overrun;
    } eim_events_t;

    // Register port request
    typedef struct packed {
        logic [5:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } eim_req_t;

    // Whole state of the block
    typedef struct packed {
        logic [15:0] mask;
        logic [15:0] cause;
        logic [15:0] rdata;
        logic        irq;
    } eim_state_t;

endpackage

// *** test/eim_host_model.sv ***
// Host side model: watches the interrupt line and counts its rising edges
`timescale 1ns/1ps
`default_nettype none
module eim_host_model (
    // Clock and reset
    input  wire logic       sys_clk_i,
    input  wire logic       rst_i,
    // Interrupt input and edge count
    input  wire logic       irq_i,
    output logic [7:0]      irq_count_o
);
    // Whole state of the host model
    typedef struct packed {
        logic       irq;
        logic [7:0] count;
    } eim_host_state_t;
    eim_host_state_t host_reg;
    eim_host_state_t host_next;
    // Level input, so only new assertions are counted as new requests
    always_comb begin
        host_next     = host_reg;
        host_next.irq = irq_i;
        if (irq_i && !host_reg.irq) begin
            host_next.count = host_reg.count + 8'h01;
        end
    end
    // Host state register
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            host_reg <= '0;
        end else begin
            host_reg <= host_next;
        end
    end
    assign irq_count_o = host_reg.count;
endmodule
`default_nettype wire

// *** test/ethernet_interrupt_mask_tb_top.sv ***
// Self-checking bench of the interrupt enable mask block
`timescale 1ns/1ps
`default_nettype none
module ethernet_interrupt_mask_tb_top;
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    eim_pkg::eim_req_t req = '0;
    eim_pkg::eim_events_t ev = '0;
    logic [15:0] rdata, en;
    logic irq;
    logic [7:0] irq_count;
    int miscompares = 0, compares = 0, cycles = 0;
    always #10 sys_clk_i = ~sys_clk_i;
    eim_ctrl i_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .req_i(req), .rdata_o(rdata),
        .events_i(ev), .irq_enable_o(en), .irq_o(irq));
    eim_host_model i_host (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .irq_i(irq),
        .irq_count_o(irq_count));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("Counts: %0d compares, %0d miscompares", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // One-cycle strobe, then idle; outputs are sampled one edge later
    task automatic access(input logic [5:0] a, input logic [15:0] d, input logic w);
        @(posedge sys_clk_i);
        req <= {a, d, w, ~w};
        @(posedge sys_clk_i);
        req <= '0;
        #1;
    endtask
    task automatic pulse(input logic [15:0] e);
        @(posedge sys_clk_i);
        ev <= eim_pkg::eim_events_t'(e);
        @(posedge sys_clk_i);
        ev <= '0;
    endtask
    task automatic settle();
        repeat (2) @(posedge sys_clk_i);
        #1;
    endtask
    task automatic t_reset_and_map();
        access(eim_pkg::MASK_OFFSET, 16'h0000, 1'b0);
        chk(rdata, 16'h0000);
        chk(en, 16'h0000);
        access(eim_pkg::MASK_OFFSET, 16'h7fff, 1'b1);
        access(eim_pkg::MASK_OFFSET, 16'h0000, 1'b0);
        chk(rdata, 16'h7fff);
        access(6'h3f, 16'h0000, 1'b0);
        chk(rdata, 16'h0000);
        settle();
        chk({15'h0000, irq}, 16'h0000);
        $display("Test reset and map done");
    endtask
    // Each source alone: other sources blocked by its enable, itself blocked with all enables clear, passed by its own
    task automatic t_sources();
        logic [15:0] e;
        for (int b = 0; b < 15; b++) begin
            e = 16'h0001 << b;
            access(eim_pkg::MASK_OFFSET, e, 1'b1);
            chk(en, e);
            pulse(~e & 16'h7fff);
            settle();
            chk({15'h0000, irq}, 16'h0000);
            access(eim_pkg::CAUSE_OFFSET, 16'h7fff, 1'b1);
            access(eim_pkg::MASK_OFFSET, 16'h0000, 1'b1);
            pulse(e);
            settle();
            chk({15'h0000, irq}, 16'h0000);
            access(eim_pkg::MASK_OFFSET, e, 1'b1);
            settle();
            chk({15'h0000, irq}, 16'h0001);
            access(eim_pkg::CAUSE_OFFSET, 16'h0000, 1'b0);
            chk(rdata, e);
            access(eim_pkg::CAUSE_OFFSET, 16'h0000, 1'b1);
            settle();
            chk({15'h0000, irq}, 16'h0001);
            access(eim_pkg::CAUSE_OFFSET, e, 1'b1);
            settle();
            chk({15'h0000, irq}, 16'h0000);
        end
        chk({8'h00, irq_count}, 16'h000f);
        $display("Test sources done");
    endtask
    // Hang guard at cycle 8000, some 7500 cycles above the expected run of about 440 cycles
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 8000) begin
            miscompares++;
            print_verdict();
        end
    end
    initial begin
        repeat (6) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        t_reset_and_map();
        t_sources();
        print_verdict();
    end
endmodule
`default_nettype wire
